// ---- logic/mpps_top.sv ----
// Summary of operation
// - Eight preset targets, chosen by select contacts
// - Each stage owns target, speed, ramp times
// - Select contacts decode binary, 000 is stage one
// - Open contact reads 0, default pattern 000
// - Setup low digit enables multistage sequencing
// - Interval dwell between stages, zero skips
// - Repeat sequence cycle-count times, zero forever
// - Mode value 5 enables register position
// - Move type 0 incremental, 1 absolute
// - Feedback select blocks battery; when clear, absolute start loads encoder
// - Trigger write starts move, self-clears
// - Ramp times 0..32000 ms, default 100
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module mpps_top
  import mpps_pkg::*;
#(
  parameter int TICK_CYCLES = mpps_pkg::TICK_CYC  // Cycles per ms
) (
  input wire logic CORE_CLK_I,                     // Core clock
  input wire logic RST_B_I,                        // Async reset, low
  input wire logic [mpps_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write addr
  input wire logic S_AXI_AWVALID_I,                // Write addr valid
  output logic S_AXI_AWREADY_O,                    // Write addr ready
  input wire logic [31:0] S_AXI_WDATA_I,           // Write data
  input wire logic [3:0] S_AXI_WSTRB_I,            // Write strobes
  input wire logic S_AXI_WVALID_I,                 // Write data valid
  output logic S_AXI_WREADY_O,                     // Write data ready
  output logic [1:0] S_AXI_BRESP_O,                // Write response
  output logic S_AXI_BVALID_O,                     // Response valid
  input wire logic S_AXI_BREADY_I,                 // Response ready
  input wire logic [mpps_pkg::ADDR_W-1:0] S_AXI_ARADDR_I, // Read addr
  input wire logic S_AXI_ARVALID_I,                // Read addr valid
  output logic S_AXI_ARREADY_O,                    // Read addr ready
  output logic [31:0] S_AXI_RDATA_O,               // Read data
  output logic [1:0] S_AXI_RRESP_O,                // Read response
  output logic S_AXI_RVALID_O,                     // Read data valid
  input wire logic S_AXI_RREADY_I,                 // Read data ready
  input wire logic [mpps_pkg::SEL_W-1:0] STAGE_SELECT_I, // Contacts 2..0
  input wire logic START_I,                        // Start contact
  input wire logic [mpps_pkg::POS_W-1:0] ENC_POS_I, // Encoder abs pos
  output logic [mpps_pkg::POS_W-1:0] CMD_POS_O,    // Commanded position
  output mpps_pkg::mpps_ramp_t RAMP_O,             // Active ramp times
  output logic [mpps_pkg::SEL_W-1:0] STAGE_O,      // Active stage
  output logic BUSY_O,                             // Sequence running
  output logic BATT_BLOCK_O                        // Battery prot blocked
);
  import mpps_pkg::*;

  // Elaboration check: the millisecond divider counts in 16 bits
  // and needs at least two cycles per tick
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_tick_range
    $error("TICK_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [PAR_W-1:0] mode_reg;        // Control mode
  logic move_abs_reg;                // Absolute when set
  logic trig_reg;                    // Self-clearing trigger
  logic [PAR_W-1:0] setup_reg;       // Stage count and enable
  logic [PAR_W-1:0] cycles_reg;      // Repeats, zero is forever
  logic fbsel_reg;                   // Feedback select
  mpps_stage_t stage_reg [NUM_STAGES]; // Per-stage settings
  logic [POS_W-1:0] cmd_pos_reg;     // Commanded position
  logic [POS_W-1:0] goal_reg;        // Current stage goal
  mpps_state_t state_reg;            // Sequencer state
  logic [SEL_W-1:0] idx_reg;         // Active stage
  logic [PAR_W-1:0] cyc_done_reg;    // Completed cycles
  logic [PAR_W-1:0] dwell_reg;       // Remaining dwell ticks
  logic [15:0] tick_cnt_reg;         // Millisecond divider
  logic tick_reg;                    // One-cycle ms enable
  logic start_d_reg;                 // Start contact history
  logic aw_hold_reg, w_hold_reg;     // Captured write halves
  logic [ADDR_W-1:0] awaddr_reg;     // Captured write address
  logic [31:0] wdata_reg;            // Captured write data

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic mode_on, ms_en, start_req, wr_fire, in_pos;
  logic [3:0] nstg;                  // Stages in sequence
  logic [2:0] wr_idx;                // Stage slot of write
  logic [15:0] wr_ramp;              // Clamped ramp value
  logic [POS_W-1:0] step;            // Speed as position word
  logic [POS_W-1:0] diff;            // Goal minus command

  assign mode_on = (mode_reg == MODE_IRPOS);
  assign ms_en = setup_reg[0];
  assign nstg = (setup_reg[7:4] == 4'h0) ? 4'h1 :
                (setup_reg[7:4] > 4'h8) ? 4'h8 : setup_reg[7:4];
  assign start_req = mode_on && (state_reg == MPPS_IDLE) &&
                     (trig_reg || (START_I && !start_d_reg));
  assign wr_fire = aw_hold_reg && w_hold_reg && !S_AXI_BVALID_O;
  assign wr_idx = awaddr_reg[4:2];
  assign wr_ramp = (wdata_reg[15:0] > RAMP_MAX) ? RAMP_MAX :
                   wdata_reg[15:0];
  assign step = {16'h0000, (stage_reg[idx_reg].speed == 16'h0000) ?
                 SPEED_RST : stage_reg[idx_reg].speed};
  assign diff = goal_reg - cmd_pos_reg;
  assign in_pos = (diff == '0);

  // Goal of a stage launched from a given base position
  function automatic logic [POS_W-1:0] goal_of(
    input logic [SEL_W-1:0] idx, input logic [POS_W-1:0] base);
    if (move_abs_reg) begin
      goal_of = stage_reg[idx].target;
    end else begin
      goal_of = base + stage_reg[idx].target;
    end
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data taken independently, then one response
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY_O <= !aw_hold_reg && !S_AXI_AWREADY_O;
      S_AXI_WREADY_O <= !w_hold_reg && !S_AXI_WREADY_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_fire) begin
        // Read-only and unmapped targets below OFS_TARGET answer with an error; 0xe0 and up answer OKAY
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (awaddr_reg < OFS_TARGET &&
                          awaddr_reg > OFS_FBSEL) ? RESP_SLVERR :
                         RESP_OKAY;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------
  // Software writes; the trigger clears itself one cycle after it is set
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_reg <= '0;
      move_abs_reg <= 1'b0;
      trig_reg <= 1'b0;
      setup_reg <= SETUP_RST;
      cycles_reg <= '0;
      fbsel_reg <= 1'b0;
      for (int i = 0; i < NUM_STAGES; i++) begin
        stage_reg[i] <= '{target: '0, speed: SPEED_RST,
                          accel: RAMP_RST, decel: RAMP_RST,
                          interval: '0};
      end
    end else begin
      if (trig_reg) begin
        trig_reg <= 1'b0;
      end
      if (wr_fire && S_AXI_WSTRB_I != 4'h0) begin
        case (awaddr_reg[7:5])
          3'h0: begin
            case (awaddr_reg[4:2])
              3'h0: mode_reg <= wdata_reg[15:0];
              3'h1: move_abs_reg <= wdata_reg[0];
              3'h2: begin
                // A new write wins over the hardware clear
                if (wdata_reg[15:0] == 16'h0001) begin
                  trig_reg <= 1'b1;
                end
              end
              3'h3: setup_reg <= wdata_reg[15:0];
              3'h4: cycles_reg <= wdata_reg[15:0];
              3'h5: fbsel_reg <= wdata_reg[0];
              default: ;
            endcase
          end
          3'h2: stage_reg[wr_idx].target <= wdata_reg;
          3'h3: stage_reg[wr_idx].speed <= wdata_reg[15:0];
          3'h4: stage_reg[wr_idx].accel <= wr_ramp;
          3'h5: stage_reg[wr_idx].decel <= wr_ramp;
          3'h6: stage_reg[wr_idx].interval <= wdata_reg[15:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  // One read at a time; data registered with its valid
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= '0;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !S_AXI_ARREADY_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O <= RESP_OKAY;
        S_AXI_RDATA_O <= '0;
        case (S_AXI_ARADDR_I[7:5])
          3'h0: begin
            case (S_AXI_ARADDR_I[4:2])
              3'h0: S_AXI_RDATA_O <= {16'h0000, mode_reg};
              3'h1: S_AXI_RDATA_O <= {31'h0, move_abs_reg};
              3'h2: S_AXI_RDATA_O <= {31'h0, trig_reg};
              3'h3: S_AXI_RDATA_O <= {16'h0000, setup_reg};
              3'h4: S_AXI_RDATA_O <= {16'h0000, cycles_reg};
              3'h5: S_AXI_RDATA_O <= {31'h0, fbsel_reg};
              3'h6: S_AXI_RDATA_O <= {cyc_done_reg, 8'h00,
                                      2'b00, mode_on, state_reg,
                                      idx_reg};
              default: S_AXI_RDATA_O <= cmd_pos_reg;
            endcase
          end
          3'h2: S_AXI_RDATA_O <= stage_reg[S_AXI_ARADDR_I[4:2]].target;
          3'h3: S_AXI_RDATA_O <=
                  {16'h0000, stage_reg[S_AXI_ARADDR_I[4:2]].speed};
          3'h4: S_AXI_RDATA_O <=
                  {16'h0000, stage_reg[S_AXI_ARADDR_I[4:2]].accel};
          3'h5: S_AXI_RDATA_O <=
                  {16'h0000, stage_reg[S_AXI_ARADDR_I[4:2]].decel};
          3'h6: S_AXI_RDATA_O <=
                  {16'h0000, stage_reg[S_AXI_ARADDR_I[4:2]].interval};
          default: S_AXI_RRESP_O <= RESP_SLVERR;
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Millisecond enable
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
      start_d_reg <= 1'b0;
    end else begin
      start_d_reg <= START_I;
      tick_reg <= (tick_cnt_reg == 16'(TICK_CYCLES - 1));
      if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= '0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stage sequencer
  // ---------------------------------------------------------------
  // Launches stages, steps the command, dwells and counts cycles
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= MPPS_IDLE;
      idx_reg <= '0;
      cyc_done_reg <= '0;
      dwell_reg <= '0;
      cmd_pos_reg <= '0;
      goal_reg <= '0;
    end else if (!mode_on) begin
      state_reg <= MPPS_IDLE;
    end else begin
      case (state_reg)
        MPPS_IDLE: begin
          if (start_req) begin
            // Sequence starts at stage one, else contacts pick it
            idx_reg <= ms_en ? 3'h0 : STAGE_SELECT_I;
            cyc_done_reg <= '0;
            state_reg <= MPPS_MOVE;
            if (move_abs_reg && !fbsel_reg) begin
              cmd_pos_reg <= ENC_POS_I;
            end
            goal_reg <= goal_of(ms_en ? 3'h0 : STAGE_SELECT_I,
                                cmd_pos_reg);
          end
        end
        MPPS_MOVE: begin
          if (in_pos) begin
            dwell_reg <= stage_reg[idx_reg].interval;
            if (!ms_en) begin
              state_reg <= MPPS_IDLE;
            end else if ({1'b0, idx_reg} == nstg - 4'h1) begin
              cyc_done_reg <= cyc_done_reg + 16'h0001;
              idx_reg <= '0;
              if (cycles_reg != '0 &&
                  cyc_done_reg + 16'h0001 >= cycles_reg) begin
                state_reg <= MPPS_IDLE;
              end else begin
                state_reg <= MPPS_DWELL;
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
              state_reg <= MPPS_DWELL;
            end
          end else if (tick_reg) begin
            // Step at the stage speed, landing exactly on goal
            if (!diff[POS_W-1] && diff > step) begin
              cmd_pos_reg <= cmd_pos_reg + step;
            end else if (diff[POS_W-1] && (-diff) > step) begin
              cmd_pos_reg <= cmd_pos_reg - step;
            end else begin
              cmd_pos_reg <= goal_reg;
            end
          end
        end
        MPPS_DWELL: begin
          if (dwell_reg == '0) begin
            goal_reg <= goal_of(idx_reg, cmd_pos_reg);
            state_reg <= MPPS_MOVE;
          end else if (tick_reg) begin
            dwell_reg <= dwell_reg - 16'h0001;
          end
        end
        default: state_reg <= MPPS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ramp times follow the register one cycle later, even mid-move
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RAMP_O <= '{accel: RAMP_RST, decel: RAMP_RST};
      CMD_POS_O <= '0;
      STAGE_O <= '0;
      BUSY_O <= 1'b0;
      BATT_BLOCK_O <= 1'b0;
    end else begin
      RAMP_O <= '{accel: stage_reg[idx_reg].accel,
                  decel: stage_reg[idx_reg].decel};
      CMD_POS_O <= cmd_pos_reg;
      STAGE_O <= idx_reg;
      BUSY_O <= (state_reg != MPPS_IDLE);
      BATT_BLOCK_O <= fbsel_reg;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_trig_clears: assert property (trig_reg |=> !trig_reg ||
      $past(wr_fire)) else $error("trigger did not clear");
  a_mode_gate: assert property (!mode_on |=>
      state_reg == MPPS_IDLE) else $error("ran outside mode");
  a_sel_decode: assert property (start_req && !ms_en |=>
      idx_reg == $past(STAGE_SELECT_I)) else $error("bad stage");
  a_seq_first: assert property (start_req && ms_en |=>
      idx_reg == 3'h0) else $error("sequence not at stage one");
  a_zero_dwell: assert property (state_reg == MPPS_DWELL &&
      dwell_reg == '0 && mode_on |=> state_reg == MPPS_MOVE)
      else $error("zero interval stalled");
  a_abs_goal: assert property (start_req && move_abs_reg |=>
      goal_reg == $past(stage_reg[STAGE_SELECT_I].target) || ms_en)
      else $error("absolute goal wrong");
  a_inc_goal: assert property (start_req && !move_abs_reg &&
      !ms_en |=> goal_reg == $past(cmd_pos_reg) +
      $past(stage_reg[STAGE_SELECT_I].target))
      else $error("incremental goal wrong");
  a_ramp_limit: assert property (RAMP_O.accel <= RAMP_MAX &&
      RAMP_O.decel <= RAMP_MAX) else $error("ramp over limit");
  a_batt_block: assert property (##1 BATT_BLOCK_O ==
      $past(fbsel_reg)) else $error("battery block mismatch");
  a_cycle_stop: assert property (state_reg == MPPS_MOVE && in_pos &&
      ms_en && mode_on && {1'b0, idx_reg} == nstg - 4'h1 &&
      cycles_reg == '0 |=> state_reg == MPPS_DWELL)
      else $error("endless cycling stopped");
  a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O) else $error("bvalid dropped");

  c_trig_start: cover property (trig_reg && start_req);
  c_seq_wrap: cover property (state_reg == MPPS_DWELL &&
      idx_reg == 3'h0 && cyc_done_reg != '0);
  c_stage8: cover property (start_req && !ms_en &&
      STAGE_SELECT_I == 3'h7);
endmodule

// ---- pkg/mpps_pkg.sv ----
package mpps_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_STAGES = 8;       // Preset stages
  localparam int SEL_W = 3;            // Stage-select contacts
  localparam int POS_W = 32;           // Position word
  localparam int PAR_W = 16;           // Parameter word
  localparam int ADDR_W = 8;           // Register byte address width
  // ---------------------------------------------------------------
  // Values after reset and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] RAMP_RST = 16'h0064;   // 100 ms
  localparam logic [15:0] RAMP_MAX = 16'h7d00;   // 32000 ms
  localparam logic [15:0] SETUP_RST = 16'h0020;  // 2 stages, disabled
  localparam logic [15:0] MODE_IRPOS = 16'h0005; // Register position mode
  localparam logic [15:0] SPEED_RST = 16'h0001;  // Counts per tick
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;      // Core clock period
  localparam int TICK_NS = 1000000;       // One millisecond
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;     // control_mode_param
  localparam logic [7:0] OFS_MOVE = 8'h04;     // move_type_select
  localparam logic [7:0] OFS_TRIG = 8'h08;     // position_trigger
  localparam logic [7:0] OFS_SETUP = 8'h0c;    // multistage_setup
  localparam logic [7:0] OFS_CYCLES = 8'h10;   // cycle_count_param
  localparam logic [7:0] OFS_FBSEL = 8'h14;    // Feedback select
  localparam logic [7:0] OFS_STATUS = 8'h18;   // Status, read only
  localparam logic [7:0] OFS_POS = 8'h1c;      // Commanded position
  localparam logic [7:0] OFS_TARGET = 8'h40;   // Eight stage targets
  localparam logic [7:0] OFS_SPEED = 8'h60;    // Eight stage speeds
  localparam logic [7:0] OFS_ACCEL = 8'h80;    // Eight accel times
  localparam logic [7:0] OFS_DECEL = 8'ha0;    // Eight decel times
  localparam logic [7:0] OFS_INTVL = 8'hc0;    // Eight intervals
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MPPS_IDLE = 2'b00,   // Waiting for start
    MPPS_MOVE = 2'b01,   // Stepping towards goal
    MPPS_DWELL = 2'b11   // Interval between stages
  } mpps_state_t;
  typedef struct packed {
    logic [POS_W-1:0] target;   // Displacement or position
    logic [PAR_W-1:0] speed;    // Max counts per tick
    logic [PAR_W-1:0] accel;    // Accel time, ms
    logic [PAR_W-1:0] decel;    // Decel time, ms
    logic [PAR_W-1:0] interval; // Dwell after stage, ms
  } mpps_stage_t;
  typedef struct packed {
    logic [PAR_W-1:0] accel;    // Active accel time
    logic [PAR_W-1:0] decel;    // Active decel time
  } mpps_ramp_t;
endpackage

// ---- verif/mpps_contact_model.sv ----
// Stage-select and start switch contacts in front of the block
module mpps_contact_model (
  input wire logic clk_i,           // Core clock
  input wire logic [2:0] sel_req_i, // Wanted contact pattern
  input wire logic push_req_i,      // Wanted start contact level
  output logic [2:0] sel_o,         // Contacts, 1 = closed
  output logic start_o              // Start contact, 1 = closed
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open contacts read 0, so the pattern starts at 000
  always @(posedge clk_i or negedge clk_i) begin
    if (!clk_i && $time == 0) begin
      sel_o <= 3'h0;
      start_o <= 1'b0;
    end else if (clk_i) begin
      sel_o <= sel_req_i;
      start_o <= push_req_i;
    end
  end
endmodule

// ---- verif/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mpps_pkg::*;
  logic clk = 0, rst_b = 0, push = 0, start_w, busy, batt;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, enc = 0, pos, rv, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic [2:0] sel = 0, sel_w, stage;
  mpps_ramp_t ramp;
  int mismatches = 0, checks = 0;
  always #20 clk = ~clk;
  mpps_contact_model i_mpps_contact_model (.clk_i(clk), .sel_req_i(sel),
    .push_req_i(push), .sel_o(sel_w), .start_o(start_w));
  mpps_top #(.TICK_CYCLES(4)) i_mpps_top (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rv), .S_AXI_RRESP_O(rr),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .STAGE_SELECT_I(sel_w), .START_I(start_w), .ENC_POS_I(enc),
    .CMD_POS_O(pos), .RAMP_O(ramp), .STAGE_O(stage), .BUSY_O(busy),
    .BATT_BLOCK_O(batt));
  // Verdict and end of run
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI4-Lite write, both halves offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    if (n == 50) begin
      mismatches++;
      final_report;
    end
  endtask
  // AXI4-Lite read, data and response kept in rdata and rresp
  task rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rdata = rv;
    rresp = rr;
    rready <= 0;
    if (n == 50) begin
      mismatches++;
      final_report;
    end
  endtask
  // Bounded wait for the busy flag to reach a level
  task wbusy(input logic lvl);
    int n;
    for (n = 0; n < 3000 && busy !== lvl; n++) @(posedge clk);
    if (n == 3000) begin
      mismatches++;
      final_report;
    end
    @(posedge clk);
  endtask
  task t_reset;
    chk(ramp, 32'h00640064);
    rd(8'h80); chk(rdata, 32'h00000064);
    rd(8'h0c); chk(rdata, 32'h00000020);
    rd(8'h08); chk(rdata, 32'h00000000);
  endtask
  task t_clamp;
    wr(8'ha4, 32'h0000ffff);
    rd(8'ha4); chk(rdata, 32'h00007d00);
    rd(8'h20); chk({30'h0, rresp}, 32'h00000002);
    wr(8'h18, 32'h00000000);
    chk({30'h0, bresp}, 32'h00000002);
  endtask
  // Trigger starts one incremental move and self-clears
  task t_trig;
    wr(8'h00, 32'h00000005);
    wr(8'h40, 32'h00000003);
    wr(8'h08, 32'h00000001);
    rd(8'h08); chk(rdata, 32'h00000000);
    wbusy(1'b1);
    wbusy(1'b0);
    chk(pos, 32'h00000003);
  endtask
  // Contacts 010 pick stage three
  task t_contacts;
    wr(8'h48, 32'h00000005);
    sel <= 3'h2;
    repeat (3) @(posedge clk);
    push <= 1;
    wbusy(1'b1);
    chk({29'h0, stage}, 32'h00000002);
    push <= 0;
    wbusy(1'b0);
    chk(pos, 32'h00000008);
  endtask
  // Two stages, one pass, 3 ms dwell after stage one
  task t_multi;
    wr(8'h44, 32'h00000004);
    wr(8'h64, 32'h00000002);
    wr(8'hc0, 32'h00000003);
    wr(8'h10, 32'h00000001);
    wr(8'h0c, 32'h00000021);
    wr(8'h08, 32'h00000001);
    wbusy(1'b1);
    wbusy(1'b0);
    chk(pos, 32'h0000000f);
    rd(8'h18); chk(rdata, 32'h00010020);
    rd(8'h1c); chk(rdata, 32'h0000000f);
    // Zero cycle count keeps running until the mode is left
    wr(8'h10, 32'h00000000);
    wr(8'h08, 32'h00000001);
    wbusy(1'b1);
    repeat (100) @(posedge clk);
    chk({31'h0, busy}, 32'h00000001);
    wr(8'h00, 32'h00000000);
    wbusy(1'b0);
    wr(8'h00, 32'h00000005);
  endtask
  // Absolute move from encoder origin, then battery block
  task t_abs;
    wr(8'h0c, 32'h00000020);
    sel <= 3'h0;
    wr(8'h04, 32'h00000001);
    wr(8'h40, 32'h00000084);
    enc <= 32'h00000080;
    wr(8'h08, 32'h00000001);
    wbusy(1'b1);
    chk(pos & 32'hfffffff0, 32'h00000080);
    wbusy(1'b0);
    chk(pos, 32'h00000084);
    wr(8'h14, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, batt}, 32'h00000001);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    t_reset;
    t_clamp;
    t_trig;
    t_contacts;
    t_multi;
    t_abs;
    final_report;
  end
endmodule
